/* File: rtl/ats_select.sv */
// Address translation path selection, protection and history bit upkeep
`timescale 1ns/100ps
`default_nettype none
module ats_select import ats_pkg::*; #(
    parameter int BMAP_N = 4,
    parameter int TLB_IW = 2
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        req_valid,
    input  wire logic [31:0] req_ea,
    input  wire logic        req_fetch,
    input  wire logic        req_store,
    input  wire logic        req_spec,
    output logic             req_ready,
    output logic             rsp_valid,
    output logic      [31:0] rsp_pa,
    output logic             rsp_fault,
    output logic      [1:0]  rsp_cause,
    output logic             rsp_direct_store,
    output logic      [23:0] rsp_ds_id,
    output logic             search_req,
    output logic      [39:0] search_vpn,
    input  wire logic        search_done,
    input  wire logic        search_found,
    input  wire logic [19:0] search_pfn,
    input  wire logic [1:0]  search_pp,
    input  wire logic        search_g,
    input  wire logic        search_r,
    input  wire logic        search_c,
    output logic             hist_wr,
    output logic             hist_ref,
    output logic             hist_chg
);
    localparam int TLB_N = 1 << TLB_IW;
    localparam int BM_WORDS = 4 * BMAP_N;

    typedef struct packed {
        ats_state_t                   st;
        logic [31:0]                  ea;
        logic                         fetch;
        logic                         store;
        logic                         spec;
        logic [2:0]                   ctl;
        logic [15:0][31:0]            seg;
        logic [TLB_N-1:0]             tv;
        logic [TLB_N-1:0][39:0]       ttag;
        logic [TLB_N-1:0][24:0]       tdat;
        logic [1:0]                   last_cause;
        logic [31:0]                  prdata;
        logic                         pready;
        logic                         pslverr;
        logic                         ready;
        logic                         rsp_valid;
        logic [31:0]                  rsp_pa;
        logic                         rsp_fault;
        logic [1:0]                   rsp_cause;
        logic                         rsp_ds;
        logic                         rsp_blk;
        logic [23:0]                  rsp_ds_id;
        logic                         search_req;
        logic [39:0]                  search_vpn;
        logic                         hist_wr;
        logic                         hist_ref;
        logic                         hist_chg;
    } ats_reg_t;

    ats_reg_t    s_q;
    ats_reg_t    s_d;
    // No reset on purpose: software must clear valid bits first
    logic [31:0] bmap [BM_WORDS];

    // Page key 0: all but store to pp 11; key 1: pp 00 none, 10 rw, else read
    function automatic logic ats_perm(input logic key, input logic [1:0] pp, input logic store);
        if (!key)
            ats_perm = !(store && pp == 2'b11);
        else
            ats_perm = (pp != 2'b00) && !(store && pp != 2'b10);
    endfunction : ats_perm

    function automatic logic ats_in(input logic [11:0] a, input logic [11:0] base);
        ats_in = a[11:6] == base[11:6];
    endfunction : ats_in

    logic        is_real;
    logic        blk_hit;
    logic [31:0] blk_pa;
    logic [1:0]  blk_pp;
    logic        blk_g;
    logic [31:0] seg;
    logic [39:0] vpn;
    logic [TLB_IW-1:0] tix;
    logic        tlb_hit;
    logic [24:0] tent;
    logic        key;

    always_comb begin
        logic [31:0] up;
        logic [31:0] lo;
        logic [14:0] msk;
        logic        bv;
        up = '0;
        lo = '0;
        msk = '0;
        bv = 1'b0;
        is_real = s_q.fetch ? !s_q.ctl[ATS_CTL_FETCH] : !s_q.ctl[ATS_CTL_DATA];
        blk_hit = 1'b0;
        blk_pa = '0;
        blk_pp = '0;
        blk_g = 1'b0;
        // Overlapping entries are a software fault; the lowest index wins
        for (int j = BMAP_N - 1; j >= 0; j--) begin
            up = bmap[2 * (j + (s_q.fetch ? 0 : BMAP_N))];
            lo = bmap[2 * (j + (s_q.fetch ? 0 : BMAP_N)) + 1];
            msk = {4'h0, up[ATS_BM_BL_LSB +: ATS_BM_BL_W]};
            bv = s_q.ctl[ATS_CTL_USER] ? up[ATS_BM_VP] : up[ATS_BM_VS];
            if (bv && ((s_q.ea[31:17] & ~msk) == (up[31:17] & ~msk))) begin
                blk_hit = 1'b1;
                blk_pa = {(lo[31:17] & ~msk) | (s_q.ea[31:17] & msk), s_q.ea[16:0]};
                blk_pp = lo[1:0];
                blk_g = lo[ATS_BM_G];
            end
        end
        seg = s_q.seg[s_q.ea[31:28]];
        vpn = {seg[ATS_VSID_W-1:0], s_q.ea[27:12]};
        tix = s_q.ea[ATS_PAGE_LSB +: TLB_IW];
        tlb_hit = s_q.tv[tix] && s_q.ttag[tix] == vpn;
        tent = s_q.tdat[tix];
        key = s_q.ctl[ATS_CTL_USER] ? seg[ATS_SEG_KP] : seg[ATS_SEG_KS];
    end

    always_comb begin
        logic ok;
        logic [24:0] fill;
        ok = 1'b0;
        fill = '0;
        s_d = s_q;
        s_d.pready = 1'b0;
        s_d.pslverr = 1'b0;
        s_d.rsp_valid = 1'b0;
        s_d.search_req = 1'b0;
        s_d.hist_wr = 1'b0;
        // APB: answer prepared in setup, pready seen at first access edge
        if (psel && !penable) begin
            s_d.pready = 1'b1;
            s_d.prdata = '0;
            if (paddr == ATS_CTRL_OFF)
                s_d.prdata = {29'h0, s_q.ctl};
            else if (paddr == ATS_STATUS_OFF)
                s_d.prdata = {28'h0, s_q.last_cause, s_q.st};
            else if (ats_in(paddr, ATS_SEG_OFF))
                s_d.prdata = s_q.seg[paddr[5:2]];
            else if (ats_in(paddr, ATS_BMAP_OFF))
                s_d.prdata = bmap[paddr[5:2]];
            else if (paddr != ATS_INVAL_OFF)
                s_d.pslverr = 1'b1;
        end
        if (psel && penable && pwrite && s_q.pready && !s_q.pslverr) begin
            if (paddr == ATS_CTRL_OFF)
                s_d.ctl = pwdata[2:0];
            else if (paddr == ATS_INVAL_OFF)
                s_d.tv = '0;
            else if (ats_in(paddr, ATS_SEG_OFF))
                s_d.seg[paddr[5:2]] = pwdata;
        end
        unique case (s_q.st)
            ATS_IDLE: begin
                if (req_valid && s_q.ready) begin
                    s_d.ea = req_ea;
                    s_d.fetch = req_fetch;
                    s_d.store = req_store;
                    s_d.spec = req_spec;
                    s_d.st = ATS_LOOK;
                end
            end
            ATS_LOOK: begin
                // Real, block and segment results all ready; pick by priority
                s_d.rsp_valid = 1'b1;
                s_d.rsp_pa = s_q.ea;
                s_d.rsp_fault = 1'b0;
                s_d.rsp_cause = ATS_CAUSE_NONE;
                s_d.rsp_ds = 1'b0;
                s_d.rsp_blk = 1'b0;
                s_d.rsp_ds_id = '0;
                s_d.st = ATS_IDLE;
                if (is_real) begin
                    s_d.rsp_pa = s_q.ea;
                end else if (blk_hit) begin
                    s_d.rsp_pa = blk_pa;
                    s_d.rsp_blk = 1'b1;
                    if (!ats_perm(1'b1, blk_pp, s_q.store)) begin
                        s_d.rsp_fault = 1'b1;
                        s_d.rsp_cause = ATS_CAUSE_PROT;
                    end else if (blk_g && (s_q.fetch || s_q.spec)) begin
                        s_d.rsp_fault = 1'b1;
                        s_d.rsp_cause = ATS_CAUSE_ATTR;
                    end
                end else if (seg[ATS_SEG_T]) begin
                    s_d.rsp_ds = 1'b1;
                    s_d.rsp_ds_id = seg[ATS_VSID_W-1:0];
                    if (s_q.fetch) begin
                        s_d.rsp_fault = 1'b1;
                        s_d.rsp_cause = ATS_CAUSE_ATTR;
                    end
                end else if (s_q.fetch && seg[ATS_SEG_N]) begin
                    s_d.rsp_fault = 1'b1;
                    s_d.rsp_cause = ATS_CAUSE_ATTR;
                end else if (!tlb_hit) begin
                    s_d.rsp_valid = 1'b0;
                    s_d.search_req = 1'b1;
                    s_d.search_vpn = vpn;
                    s_d.st = ATS_SEARCH;
                end else begin
                    s_d.rsp_pa = {tent[24:5], s_q.ea[11:0]};
                    ok = ats_perm(key, tent[4:3], s_q.store);
                    if (!ok) begin
                        s_d.rsp_fault = 1'b1;
                        s_d.rsp_cause = ATS_CAUSE_PROT;
                    end else if (tent[2] && (s_q.fetch || s_q.spec)) begin
                        s_d.rsp_fault = 1'b1;
                        s_d.rsp_cause = ATS_CAUSE_ATTR;
                    end else if (s_q.store && !tent[0]) begin
                        s_d.tdat[tix][0] = 1'b1;
                        s_d.hist_wr = 1'b1;
                        s_d.hist_ref = 1'b1;
                        s_d.hist_chg = 1'b1;
                        s_d.search_vpn = vpn;
                    end
                end
                if (s_d.rsp_valid)
                    s_d.last_cause = s_d.rsp_cause;
            end
            ATS_SEARCH: begin
                if (search_done) begin
                    if (!search_found) begin
                        s_d.rsp_valid = 1'b1;
                        s_d.rsp_fault = 1'b1;
                        s_d.rsp_cause = ATS_CAUSE_PAGE;
                        s_d.rsp_pa = s_q.ea;
                        s_d.rsp_ds = 1'b0;
                        s_d.rsp_blk = 1'b0;
                        s_d.last_cause = ATS_CAUSE_PAGE;
                        s_d.st = ATS_IDLE;
                    end else begin
                        // Fill, then look again; the retry is sure to hit
                        fill = {search_pfn, search_pp, search_g, 1'b1, search_c | s_q.store};
                        s_d.tv[tix] = 1'b1;
                        s_d.ttag[tix] = vpn;
                        s_d.tdat[tix] = fill;
                        s_d.hist_wr = s_q.store ? !(search_r && search_c) : !search_r;
                        s_d.hist_ref = 1'b1;
                        s_d.hist_chg = fill[0];
                        s_d.st = ATS_LOOK;
                    end
                end
            end
        endcase
        s_d.ready = s_d.st == ATS_IDLE;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            s_q <= '0;
        else
            s_q <= s_d;
    end

    always_ff @(posedge pclk) begin
        if (psel && penable && pwrite && s_q.pready && ats_in(paddr, ATS_BMAP_OFF))
            bmap[paddr[5:2]] <= pwdata;
    end

    assign prdata = s_q.prdata;
    assign pready = s_q.pready;
    assign pslverr = s_q.pslverr;
    assign req_ready = s_q.ready;
    assign rsp_valid = s_q.rsp_valid;
    assign rsp_pa = s_q.rsp_pa;
    assign rsp_fault = s_q.rsp_fault;
    assign rsp_cause = s_q.rsp_cause;
    assign rsp_direct_store = s_q.rsp_ds;
    assign rsp_ds_id = s_q.rsp_ds_id;
    assign search_req = s_q.search_req;
    assign search_vpn = s_q.search_vpn;
    assign hist_wr = s_q.hist_wr;
    assign hist_ref = s_q.hist_ref;
    assign hist_chg = s_q.hist_chg;

    default clocking ats_cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_real_passes_ea: assert property (s_q.st == ATS_LOOK && is_real |=>
        s_q.rsp_valid && !s_q.rsp_fault && s_q.rsp_pa == $past(s_q.ea)) else $error("real mode address changed");
    a_block_wins: assert property (s_q.st == ATS_LOOK && !is_real && blk_hit |=>
        s_q.rsp_valid && s_q.rsp_pa == $past(blk_pa) && !s_q.rsp_ds && !s_q.search_req) else $error("block hit lost");
    a_page_offset: assert property (s_q.rsp_valid && !s_q.rsp_blk |->
        s_q.rsp_pa[11:0] == s_q.ea[11:0]) else $error("page offset altered");
    a_block_offset: assert property (s_q.rsp_valid && s_q.rsp_blk |->
        s_q.rsp_pa[16:0] == s_q.ea[16:0]) else $error("block offset altered");
    a_ds_fetch: assert property (s_q.st == ATS_LOOK && !is_real && !blk_hit && seg[ATS_SEG_T] && s_q.fetch |=>
        s_q.rsp_fault && s_q.rsp_cause == ATS_CAUSE_ATTR && s_q.rsp_ds) else $error("direct-store fetch not faulted");
    a_noexec_fetch: assert property (s_q.st == ATS_LOOK && !is_real && !blk_hit && !seg[ATS_SEG_T] &&
        seg[ATS_SEG_N] && s_q.fetch |=> s_q.rsp_fault) else $error("no-execute fetch allowed");
    a_miss_search: assert property (s_q.st == ATS_LOOK && !is_real && !blk_hit && !seg[ATS_SEG_T] &&
        !(s_q.fetch && seg[ATS_SEG_N]) && !tlb_hit |=> s_q.search_req && s_q.st == ATS_SEARCH && !s_q.rsp_valid)
        else $error("miss without search");
    a_retry_hits: assert property (s_q.st == ATS_SEARCH && search_done && search_found |=>
        s_q.st == ATS_LOOK ##1 s_q.rsp_valid && !s_q.search_req) else $error("retry did not hit");
    a_page_fault: assert property (s_q.st == ATS_SEARCH && search_done && !search_found |=>
        s_q.rsp_valid && s_q.rsp_fault && s_q.rsp_cause == ATS_CAUSE_PAGE) else $error("page fault missing");
    a_store_history: assert property (s_q.st == ATS_SEARCH && search_done && search_found && s_q.store &&
        !(search_r && search_c) |=> s_q.hist_wr && s_q.hist_ref && s_q.hist_chg) else $error("store history not set");
endmodule : ats_select
`default_nettype wire

/* File: pkg/ats_pkg.sv */
// Constants and types shared by the address translation select block
package ats_pkg;
    // APB register byte offsets
    localparam logic [11:0] ATS_CTRL_OFF   = 12'h000;
    localparam logic [11:0] ATS_STATUS_OFF = 12'h004;
    localparam logic [11:0] ATS_INVAL_OFF  = 12'h008;
    localparam logic [11:0] ATS_SEG_OFF    = 12'h040;
    localparam logic [11:0] ATS_BMAP_OFF   = 12'h080;
    // machine_state_word fields
    localparam int          ATS_CTL_FETCH  = 0;
    localparam int          ATS_CTL_DATA   = 1;
    localparam int          ATS_CTL_USER   = 2;
    localparam logic [2:0]  ATS_CTL_RST    = 3'h0;
    // Segment descriptor fields
    localparam int          ATS_SEG_T      = 31;
    localparam int          ATS_SEG_KS     = 30;
    localparam int          ATS_SEG_KP     = 29;
    localparam int          ATS_SEG_N      = 28;
    localparam int          ATS_VSID_W     = 24;
    // block_map_entry fields: upper word, then lower word; then the page number LSB of the address
    localparam int          ATS_BM_TAG_LSB = 17;
    localparam int          ATS_BM_BL_LSB  = 2;
    localparam int          ATS_BM_BL_W    = 11;
    localparam int          ATS_BM_VS      = 1;
    localparam int          ATS_BM_VP      = 0;
    localparam int          ATS_BM_G       = 3;
    localparam int          ATS_PAGE_LSB   = 12;
    // Fault causes
    localparam logic [1:0]  ATS_CAUSE_NONE = 2'h0;
    localparam logic [1:0]  ATS_CAUSE_PAGE = 2'h1;
    localparam logic [1:0]  ATS_CAUSE_PROT = 2'h2;
    localparam logic [1:0]  ATS_CAUSE_ATTR = 2'h3;
    typedef enum logic [1:0] {ATS_IDLE, ATS_LOOK, ATS_SEARCH} ats_state_t;
endpackage : ats_pkg

/* File: tb/ats_table_model.sv */
// Memory table search responder facing the translation select block
`timescale 1ns/100ps
`default_nettype none
module ats_table_model (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        search_req,
    input  wire logic [39:0] search_vpn,
    output logic             search_done,
    output logic             search_found,
    output logic      [19:0] search_pfn,
    output logic      [1:0]  search_pp,
    output logic             search_g,
    output logic             search_r,
    output logic             search_c
);
    // Entry contents follow the page bits so the bench can predict them
    typedef struct packed {
        logic        busy;
        logic [2:0]  wait_n;
        logic [15:0] vpn;
        logic        done;
        logic [25:0] ans;
    } ats_tm_t;
    ats_tm_t st_q;
    ats_tm_t st_d;
    always_comb begin
        st_d = st_q;
        st_d.done = 1'b0;
        // Idle answer lines toggle, so a stale answer is never trusted
        st_d.ans = ~st_q.ans;
        if (search_req) begin
            st_d.busy = 1'b1;
            st_d.vpn = search_vpn[15:0];
            st_d.wait_n = search_vpn[6] ? 3'h5 : 3'h0;
        end else if (st_q.busy && st_q.wait_n != 3'h0) begin
            st_d.wait_n = st_q.wait_n - 3'h1;
        end else if (st_q.busy) begin
            st_d.busy = 1'b0;
            st_d.done = 1'b1;
            st_d.ans = {st_q.vpn[3:0] != 4'hf, 4'ha, st_q.vpn, st_q.vpn[5:4], st_q.vpn[7], st_q.vpn[0], st_q.vpn[1]};
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end
    assign search_done = st_q.done;
    assign {search_found, search_pfn, search_pp, search_g, search_r, search_c} = st_q.ans;
endmodule : ats_table_model
`default_nettype wire

/* File: tb/ats_select_tb.sv */
// Self-checking bench for the address translation select block
`timescale 1ns/100ps
`default_nettype none
module ats_select_tb import ats_pkg::*;;
    localparam logic HI = 1'b1;
    localparam logic LO = 1'b0;
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, req_ea = 32'h0, prdata, rsp_pa, a_rd;
    logic        req_valid = 1'b0, req_fetch = 1'b0, req_store = 1'b0, req_spec = 1'b0;
    logic        pready, pslverr, req_ready, rsp_valid, rsp_fault, rsp_direct_store, a_err;
    logic        search_req, search_done, search_found, search_g, search_r, search_c;
    logic        hist_wr, hist_ref, hist_chg, h_ref, h_chg, r_ds, no_pa = 1'b0;
    logic [1:0]  rsp_cause, search_pp;
    logic [23:0] rsp_ds_id, r_id;
    logic [19:0] search_pfn;
    logic [39:0] search_vpn, s_vpn;
    int          n_srch = 0, n_hw = 0, k, bad_count = 0, checks_done = 0;
    ats_select ats_select_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .req_valid(req_valid), .req_ea(req_ea), .req_fetch(req_fetch), .req_store(req_store), .req_spec(req_spec),
        .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_pa(rsp_pa), .rsp_fault(rsp_fault), .rsp_cause(rsp_cause),
        .rsp_direct_store(rsp_direct_store), .rsp_ds_id(rsp_ds_id), .search_req(search_req),
        .search_vpn(search_vpn), .search_done(search_done), .search_found(search_found), .search_pfn(search_pfn),
        .search_pp(search_pp), .search_g(search_g), .search_r(search_r), .search_c(search_c),
        .hist_wr(hist_wr), .hist_ref(hist_ref), .hist_chg(hist_chg));
    ats_table_model ats_table_model_i (.pclk(pclk), .presetn(presetn), .search_req(search_req),
        .search_vpn(search_vpn), .search_done(search_done), .search_found(search_found), .search_pfn(search_pfn),
        .search_pp(search_pp), .search_g(search_g), .search_r(search_r), .search_c(search_c));
    always #20 pclk = ~pclk;
    always @(posedge pclk) begin
        if (search_req === 1'b1) begin
            n_srch++;
            s_vpn = search_vpn;
        end
        if (hist_wr === 1'b1) begin
            n_hw++;
            h_ref = hist_ref;
            h_chg = hist_chg;
        end
    end
    task automatic chk(input logic [39:0] seen, input logic [39:0] exp, input string what);
        checks_done++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic close_out();
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : close_out
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        a_rd = prdata;
        a_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic xc(input logic [31:0] ea, input logic f, s, sp, input logic [31:0] pa, input logic [1:0] cs);
        @(posedge pclk);
        req_valid <= 1'b1;
        req_ea <= ea;
        req_fetch <= f;
        req_store <= s;
        req_spec <= sp;
        do @(posedge pclk); while (req_ready !== 1'b1);
        req_valid <= 1'b0;
        do @(posedge pclk); while (rsp_valid !== 1'b1);
        chk(40'(rsp_cause), 40'(cs), "cause");
        chk(40'(rsp_fault), 40'(cs != ATS_CAUSE_NONE), "fault");
        if (cs == ATS_CAUSE_NONE && !no_pa) chk(40'(rsp_pa), 40'(pa), "address");
        r_ds = rsp_direct_store;
        r_id = rsp_ds_id;
        // History pulses come with or before the answer; wait a phase so the monitor has sampled them
        @(negedge pclk);
    endtask : xc
    initial begin
        repeat (20000) @(posedge pclk);
        bad_count++;
        close_out();
    end
    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        apb(LO, ATS_CTRL_OFF, 32'h0);
        chk(40'(a_rd), 40'h0, "control reset");
        apb(LO, 12'h0c0, 32'h0);
        chk(40'(a_err), 40'h1, "unmapped error");
        for (int i = 0; i < 8; i++) apb(HI, ATS_BMAP_OFF + 12'(8 * i), 32'h0);
        xc(32'h1234_5678, HI, LO, LO, 32'h1234_5678, ATS_CAUSE_NONE);
        apb(HI, ATS_CTRL_OFF, 32'h1);
        xc(32'h3000_0abc, LO, HI, LO, 32'h3000_0abc, ATS_CAUSE_NONE);
        chk(40'(n_srch), 40'h0, "real mode search");
        $display("test real_mode finished");
        apb(HI, ATS_CTRL_OFF, 32'h3);
        apb(HI, ATS_SEG_OFF + 12'h4, 32'h0000_0123);
        xc(32'h1002_0345, LO, LO, LO, 32'ha002_0345, ATS_CAUSE_NONE);
        chk(s_vpn, 40'h00_0123_0020, "search vpn");
        chk(40'({h_ref, n_hw[3:0]}), 40'h11, "load history");
        xc(32'h1002_0345, LO, LO, LO, 32'ha002_0345, ATS_CAUSE_NONE);
        xc(32'h1004_0678, LO, LO, LO, 32'ha004_0678, ATS_CAUSE_NONE);
        xc(32'h1004_0678, LO, HI, LO, 32'ha004_0678, ATS_CAUSE_NONE);
        chk(40'({n_srch[3:0], n_hw[3:0], h_ref, h_chg}), 40'h08f, "store hit history");
        xc(32'h1001_1abc, LO, HI, LO, 32'ha001_1abc, ATS_CAUSE_NONE);
        chk(40'({n_hw[3:0], h_ref, h_chg}), 40'h13, "store search history");
        xc(32'h1000_f000, LO, LO, LO, 32'h0, ATS_CAUSE_PAGE);
        apb(HI, ATS_INVAL_OFF, 32'h0);
        k = n_srch;
        // Entry still cached before the flush, so only the flush forces a search
        xc(32'h1001_1abc, LO, LO, LO, 32'ha001_1abc, ATS_CAUSE_NONE);
        chk(40'(n_srch - k), 40'h1, "search after flush");
        $display("test page finished");
        apb(HI, ATS_SEG_OFF + 12'h8, 32'h2000_0456);
        apb(HI, ATS_CTRL_OFF, 32'h7);
        xc(32'h2000_1000, LO, LO, LO, 32'h0, ATS_CAUSE_PROT);
        xc(32'h2001_1000, LO, LO, LO, 32'ha001_1000, ATS_CAUSE_NONE);
        xc(32'h2001_1000, LO, HI, LO, 32'h0, ATS_CAUSE_PROT);
        xc(32'h2002_1000, LO, HI, LO, 32'ha002_1000, ATS_CAUSE_NONE);
        xc(32'h2002_1000, HI, LO, LO, 32'ha002_1000, ATS_CAUSE_NONE);
        apb(HI, ATS_CTRL_OFF, 32'h3);
        xc(32'h2000_1000, LO, HI, LO, 32'ha000_1000, ATS_CAUSE_NONE);
        xc(32'h2003_1000, LO, HI, LO, 32'h0, ATS_CAUSE_PROT);
        $display("test protection finished");
        apb(HI, ATS_SEG_OFF + 12'h10, 32'h1000_0000);
        xc(32'h4000_1000, HI, LO, LO, 32'h0, ATS_CAUSE_ATTR);
        xc(32'h4000_1000, LO, LO, LO, 32'ha000_1000, ATS_CAUSE_NONE);
        apb(HI, ATS_SEG_OFF + 12'h14, 32'h80ab_cdef);
        k = n_srch;
        no_pa = 1'b1;
        xc(32'h5123_4567, LO, HI, LO, 32'h0, ATS_CAUSE_NONE);
        chk(40'({r_ds, r_id}), 40'h1ab_cdef, "direct store id");
        chk(40'(n_srch - k), 40'h0, "direct store search");
        xc(32'h5123_4567, HI, LO, LO, 32'h0, ATS_CAUSE_ATTR);
        no_pa = 1'b0;
        xc(32'h1008_1000, HI, LO, LO, 32'h0, ATS_CAUSE_ATTR);
        xc(32'h1008_1000, LO, LO, HI, 32'h0, ATS_CAUSE_ATTR);
        xc(32'h1008_1000, LO, LO, LO, 32'ha008_1000, ATS_CAUSE_NONE);
        $display("test segment finished");
        apb(HI, ATS_BMAP_OFF + 12'h20, 32'h5000_0002);
        apb(HI, ATS_BMAP_OFF + 12'h24, 32'h7000_0002);
        xc(32'h5001_2345, LO, LO, LO, 32'h7001_2345, ATS_CAUSE_NONE);
        chk(40'(r_ds), 40'h0, "block over direct store");
        no_pa = 1'b1;
        xc(32'h5002_0000, LO, LO, LO, 32'h0, ATS_CAUSE_NONE);
        chk(40'(r_ds), 40'h1, "outside small block");
        no_pa = 1'b0;
        apb(HI, ATS_BMAP_OFF + 12'h28, 32'h6000_1ffe);
        apb(HI, ATS_BMAP_OFF + 12'h2c, 32'h9000_0001);
        xc(32'h6abc_def0, LO, LO, LO, 32'h9abc_def0, ATS_CAUSE_NONE);
        xc(32'h6abc_def0, LO, HI, LO, 32'h0, ATS_CAUSE_PROT);
        apb(HI, ATS_BMAP_OFF, 32'h5000_0002);
        apb(HI, ATS_BMAP_OFF + 12'h4, 32'h7000_000a);
        xc(32'h5000_0100, HI, LO, LO, 32'h0, ATS_CAUSE_ATTR);
        apb(HI, ATS_CTRL_OFF, 32'h0);
        xc(32'h5001_2345, LO, LO, LO, 32'h5001_2345, ATS_CAUSE_NONE);
        $display("test block finished");
        close_out();
    end
endmodule : ats_select_tb
`default_nettype wire
